// [include/hwfe_pkg.sv]
// Shared constants, register map and carrier types of the haptic waveform front end
package hwfe_pkg;
    localparam int CLK_HZ    = 125_000_000;
    localparam int BASE_SPS  = 1_024_000;
    localparam int SUB_CYC   = CLK_HZ / (BASE_SPS * 8);
    localparam int ZERO_US   = 500;
    localparam int DEPTH_DEF = 1024;
    localparam int RAM_DEF   = 1024;

    localparam logic [7:0] A_CONFIG   = 8'h00;
    localparam logic [7:0] A_SOURCE   = 8'h04;
    localparam logic [7:0] A_SAMPLE   = 8'h08;
    localparam logic [7:0] A_RAM      = 8'h0c;
    localparam logic [7:0] A_PLAYEND  = 8'h10;
    localparam logic [7:0] A_SENSE    = 8'h14;
    localparam logic [7:0] A_STATUS   = 8'h18;
    localparam logic [7:0] A_READBACK = 8'h1c;

    localparam logic [1:0] SRC_DIRECT = 2'h0;
    localparam logic [1:0] SRC_QUEUE  = 2'h1;
    localparam logic [1:0] SRC_RAM    = 2'h2;
    localparam logic [1:0] SRC_TONE   = 2'h3;
    localparam logic [4:0] RB_SENSE   = 5'h12;

    localparam logic [1:0] SF_IDLE  = 2'h0;
    localparam logic [1:0] SF_RUN   = 2'h1;
    localparam logic [1:0] SF_SLEEP = 2'h2;
    localparam logic [1:0] SF_ERR   = 2'h3;

    localparam logic [2:0] EV_SENSE = 3'h1;
    localparam logic [2:0] EV_DONE  = 3'h2;
    localparam logic [2:0] EV_ERR   = 3'h3;
    localparam logic [2:0] EV_READY = 3'h7;

    localparam int RAM_ADDR_LSB = 16;
    localparam int ST_SENSE_BIT = 16;
    localparam int ST_DONE_BIT  = 17;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0] event_output_select;
        logic       auto_trig;
        logic       soft_rst;
        logic [1:0] zero_time;
        logic [2:0] rate;
        logic       lockstep;
        logic       deep_power_select;
        logic       run;
    } hwfe_cfg_t;

    typedef struct packed {
        logic       dir_fall;
        logic [2:0] sense_hold_count;
        logic [8:0] sense_threshold;
    } hwfe_sense_t;

    localparam hwfe_cfg_t   CFG_RST     = 13'h0000;
    localparam hwfe_sense_t SENSE_RST   = 13'h0000;
    localparam logic [1:0]  SRC_RST     = 2'h0;
    localparam logic [4:0]  RB_RST      = 5'h00;
    localparam logic [9:0]  PLAYEND_RST = 10'h3ff;

    typedef enum {S_IDLE, S_WAKE, S_RUN, S_SLEEP, S_ERR} hwfe_state_t;
endpackage

// [logic/hwfe_top.sv]
// Haptic waveform front end: register slave, sources, pacing, power states, sync, sensing
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module hwfe_top
    import hwfe_pkg::*;
#(
    parameter int DEPTH    = DEPTH_DEF,
    parameter int RAM_N    = RAM_DEF,
    parameter int ZERO_CYC = ZERO_US * (CLK_HZ / 1_000_000)
)(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        cs_n,
    input  wire logic [8:0]  sense_level,
    input  wire logic        fault,
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic             sync_oe,
    output logic             event_output_pin,
    output logic [11:0]      wave_out
);
    localparam int QW = $clog2(DEPTH);
    localparam int RW = $clog2(RAM_N);

    hwfe_state_t state_reg;
    hwfe_state_t state_next;
    hwfe_cfg_t   cfg_reg;
    hwfe_sense_t sense_reg;
    logic [1:0]  src_reg;
    logic [4:0]  rb_reg;
    logic [9:0]  playend_reg;
    logic [11:0] hold_reg;
    logic [2:0]  cs_q;
    logic [2:0]  sy_q;
    logic        aw_h;
    logic        w_h;
    logic [7:0]  awa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [19:0] zcnt;
    logic [10:0] subcnt;
    logic [2:0]  sub_idx;
    logic [QW:0] q_cnt;
    logic [QW-1:0] q_wp;
    logic [QW-1:0] q_rp;
    logic [11:0] q_mem [DEPTH];
    logic [11:0] ram [RAM_N];
    logic [RW-1:0] rptr;
    logic [11:0] cur;
    logic [11:0] prv;
    logic signed [12:0] tone_s;
    logic signed [12:0] tone_c;
    logic [3:0]  scnt;
    logic        sense_flag;
    logic        done_flag;
    logic        trig_act;

    wire cs_fall   = cs_q[2] & ~cs_q[1];
    wire sync_hi   = sy_q[1];
    wire sync_rise = sy_q[1] & ~sy_q[2];
    wire wipe      = sys_rst | cfg_reg.soft_rst | (state_reg == S_SLEEP);
    wire wr_go     = aw_h & w_h & ~bvalid;
    wire ar_take   = arvalid & arready;
    wire w_map     = (awa[7:5] == 3'h0) && (awa[1:0] == 2'h0);
    wire r_map     = (araddr[7:5] == 3'h0) && (araddr[1:0] == 2'h0);
    wire w_cfg     = wr_go && awa == A_CONFIG;
    wire w_src     = wr_go && awa == A_SOURCE;
    wire w_smp     = wr_go && awa == A_SAMPLE;
    wire w_ram     = wr_go && awa == A_RAM;
    wire w_end     = wr_go && awa == A_PLAYEND;
    wire w_sns     = wr_go && awa == A_SENSE;
    wire w_sta     = wr_go && awa == A_STATUS;
    wire [31:0] bm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire running   = state_reg == S_RUN;
    wire [10:0] sper = 11'(SUB_CYC) << cfg_reg.rate;
    wire sub_tick  = running && subcnt == sper - 11'h1;
    wire samp_tick = sub_tick && sub_idx == 3'h7;
    wire zdone     = state_reg == S_WAKE && zcnt == 20'h0;
    // Each linked device holds the line low until it is ready, so release means all ready
    wire sync_pull = cfg_reg.lockstep & ((!running & !zdone) | (running & ~sub_idx[2]));
    wire q_push    = w_smp && src_reg == SRC_QUEUE && q_cnt != (QW+1)'(DEPTH);
    wire q_pop     = samp_tick && src_reg == SRC_QUEUE && q_cnt != '0;
    wire ram_end   = rptr == RW'(playend_reg);
    wire trig_end  = samp_tick && src_reg == SRC_RAM && trig_act && ram_end;
    wire s_cond    = sense_reg.dir_fall ? sense_level < sense_reg.sense_threshold
                                        : sense_level > sense_reg.sense_threshold;
    wire s_fire    = s_cond && scnt == {1'b0, sense_reg.sense_hold_count};
    wire trig_go   = s_fire && cfg_reg.auto_trig && state_reg == S_IDLE;
    wire [11:0] amp  = {1'b0, ram[0][10:0]};
    wire [11:0] freq = {2'h0, ram[1][9:0]};
    wire signed [25:0] fs = $signed({1'b0, freq}) * tone_s;
    wire signed [12:0] c_n = tone_c - 13'(fs >>> 12);
    wire signed [25:0] fc = $signed({1'b0, freq}) * c_n;
    wire signed [12:0] s_n = tone_s + 13'(fc >>> 12);
    wire [11:0] tone_smp = tone_s > 13'sd2047  ? 12'hfff :
                           tone_s < -13'sd2048 ? 12'h000 : 12'(tone_s + 13'sd2048);
    wire signed [16:0] ip_d = ($signed({1'b0, cur}) - $signed({1'b0, prv}))
                              * $signed({1'b0, sub_idx});
    wire signed [16:0] ip = $signed({5'h0, prv}) + (ip_d >>> 3);
    wire [1:0] state_fld = (state_reg == S_IDLE)  ? SF_IDLE  :
                           (state_reg == S_SLEEP) ? SF_SLEEP :
                           (state_reg == S_ERR)   ? SF_ERR   : SF_RUN;

    logic [11:0] new_smp;
    logic        ev_next;
    logic [31:0] rd_mux;

    function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                        input logic [31:0] m);
        mrg = (o & ~m) | (n & m);
    endfunction

    always_comb
    begin
        case (src_reg)
            SRC_DIRECT: new_smp = hold_reg;
            SRC_QUEUE:  new_smp = (q_cnt != '0) ? q_mem[q_rp] : cur;
            SRC_RAM:    new_smp = ram[rptr];
            default:    new_smp = tone_smp;
        endcase
    end

    always_comb
    begin
        case (cfg_reg.event_output_select)
            EV_SENSE: ev_next = sense_flag;
            EV_DONE:  ev_next = done_flag;
            EV_ERR:   ev_next = state_reg == S_ERR;
            EV_READY: ev_next = samp_tick;
            default:  ev_next = 1'b0;
        endcase
    end

    always_comb
    begin
        if (araddr == A_CONFIG)
            rd_mux = {19'h0, cfg_reg};
        else if (araddr == A_SOURCE)
            rd_mux = {25'h0, rb_reg, src_reg};
        else if (araddr == A_SAMPLE)
            rd_mux = {20'h0, hold_reg};
        else if (araddr == A_PLAYEND)
            rd_mux = {22'h0, playend_reg};
        else if (araddr == A_SENSE)
            rd_mux = {19'h0, sense_reg};
        else if (araddr == A_STATUS)
            rd_mux = {14'h0, done_flag, sense_flag, 3'h0, 11'(q_cnt), state_fld};
        else if (araddr == A_READBACK)
            rd_mux = (rb_reg == RB_SENSE) ? {23'h0, sense_level} : {20'h0, wave_out};
        else
            rd_mux = 32'h0;
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:
                if (cfg_reg.run)
                    state_next = S_WAKE;
                else if (cfg_reg.deep_power_select)
                    state_next = S_SLEEP;
            S_WAKE:
                if (fault)
                    state_next = S_ERR;
                else if (!cfg_reg.run)
                    state_next = S_IDLE;
                else if (zdone && (!cfg_reg.lockstep || sync_hi))
                    state_next = S_RUN;
            S_RUN:
                if (fault)
                    state_next = S_ERR;
                else if (!cfg_reg.run)
                    state_next = S_IDLE;
            S_ERR:
                if (!fault && !cfg_reg.run)
                    state_next = S_IDLE;
            default:
                if (cs_fall)
                    state_next = S_IDLE;
        endcase
    end

    // Pin synchronisers; the third stage only serves edge detection
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cs_q <= 3'h7;
            sy_q <= 3'h7;
        end
        else
        begin
            cs_q <= {cs_q[1:0], cs_n};
            sy_q <= {sy_q[1:0], sync_in};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst || cfg_reg.soft_rst)
            state_reg <= S_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            arready <= 1'b1;
            bvalid  <= 1'b0;
            rvalid  <= 1'b0;
            aw_h    <= 1'b0;
            w_h     <= 1'b0;
            bresp   <= RESP_OKAY;
            rresp   <= RESP_OKAY;
            rdata   <= 32'h0;
            awa     <= 8'h0;
            wd      <= 32'h0;
            ws      <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_h    <= 1'b1;
                awready <= 1'b0;
                awa     <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_h    <= 1'b1;
                wready <= 1'b0;
                wd     <= wdata;
                ws     <= wstrb;
            end
            if (wr_go)
            begin
                aw_h   <= 1'b0;
                w_h    <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= w_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
            if (ar_take)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_mux;
                rresp   <= r_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Sleep holds every register at default; the bus itself stays alive
    always_ff @(posedge core_clk)
    begin
        if (wipe)
        begin
            cfg_reg     <= CFG_RST;
            sense_reg   <= SENSE_RST;
            src_reg     <= SRC_RST;
            rb_reg      <= RB_RST;
            playend_reg <= PLAYEND_RST;
            hold_reg    <= 12'h0;
            sense_flag  <= 1'b0;
            done_flag   <= 1'b0;
            trig_act    <= 1'b0;
        end
        else
        begin
            if (w_cfg)
                cfg_reg <= hwfe_cfg_t'(13'(mrg({19'h0, cfg_reg}, wd, bm)));
            if (trig_go)
                cfg_reg.run <= 1'b1;
            if (trig_end)
                cfg_reg.run <= 1'b0;
            if (w_src)
                {rb_reg, src_reg} <= 7'(mrg({25'h0, rb_reg, src_reg}, wd, bm));
            if (w_end)
                playend_reg <= 10'(mrg({22'h0, playend_reg}, wd, bm));
            if (w_sns)
                sense_reg <= hwfe_sense_t'(13'(mrg({19'h0, sense_reg}, wd, bm)));
            if (w_smp)
                hold_reg <= wd[11:0];
            // Hardware set wins over a clear in the same cycle
            sense_flag <= s_fire | (sense_flag & ~(w_sta & wd[ST_SENSE_BIT]));
            done_flag  <= trig_end | (done_flag & ~(w_sta & wd[ST_DONE_BIT]));
            trig_act   <= trig_go | (trig_act & ~trig_end & cfg_reg.run);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst || state_reg == S_SLEEP)
        begin
            for (int i = 0; i < RAM_N; i++)
                ram[i] <= 12'h0;
        end
        else if (w_ram)
            ram[wd[RAM_ADDR_LSB +: RW]] <= wd[11:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (q_push)
            q_mem[q_wp] <= wd[11:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (wipe)
        begin
            q_wp  <= '0;
            q_rp  <= '0;
            q_cnt <= '0;
        end
        else
        begin
            if (q_push)
                q_wp <= q_wp + 1'b1;
            if (q_pop)
                q_rp <= q_rp + 1'b1;
            q_cnt <= q_cnt + (QW+1)'(q_push) - (QW+1)'(q_pop);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst || state_reg != S_WAKE)
            zcnt <= 20'(ZERO_CYC) << cfg_reg.zero_time;
        else if (zcnt != 20'h0)
            zcnt <= zcnt - 20'h1;
    end

    // Pacing: eight interpolation steps per sample period
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !running)
        begin
            subcnt  <= 11'h0;
            sub_idx <= 3'h0;
        end
        else if (cfg_reg.lockstep && sync_rise)
        begin
            subcnt  <= 11'h0;
            sub_idx <= 3'h4;
        end
        else if (sub_tick)
        begin
            subcnt  <= 11'h0;
            sub_idx <= sub_idx + 3'h1;
        end
        else
            subcnt <= subcnt + 11'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !running)
        begin
            cur    <= 12'h0;
            prv    <= 12'h0;
            rptr   <= '0;
            tone_c <= $signed({1'b0, amp});
            tone_s <= 13'sh0;
        end
        else if (samp_tick)
        begin
            prv  <= cur;
            cur  <= new_smp;
            rptr <= ram_end ? '0 : rptr + 1'b1;
            if (src_reg == SRC_TONE)
            begin
                tone_c <= c_n;
                tone_s <= s_n;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !s_cond)
            scnt <= 4'h0;
        else if (scnt <= {1'b0, sense_reg.sense_hold_count})
            scnt <= scnt + 4'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wave_out         <= 12'h0;
            event_output_pin <= 1'b0;
            sync_oe          <= 1'b0;
            sync_out         <= 1'b0;
        end
        else
        begin
            wave_out         <= running ? ip[11:0] : 12'h0;
            event_output_pin <= ev_next;
            sync_oe          <= sync_pull;
            sync_out         <= 1'b0;
        end
    end

    sequence s_sleep_cs;
        state_reg == S_SLEEP && cs_fall;
    endsequence

    property p_q_cap;
        @(posedge core_clk) disable iff (sys_rst) q_cnt <= (QW+1)'(DEPTH);
    endproperty
    a_q_cap: assert property (p_q_cap) else $error("queue count above capacity");

    property p_q_push;
        @(posedge core_clk) disable iff (sys_rst)
            (q_push && !q_pop && !wipe) |=> q_cnt == $past(q_cnt) + 1'b1;
    endproperty
    a_q_push: assert property (p_q_push) else $error("write not appended");

    property p_q_pop;
        @(posedge core_clk) disable iff (sys_rst)
            (q_pop && !wipe) |=> q_rp == $past(q_rp) + 1'b1 && cur == $past(q_mem[q_rp]);
    endproperty
    a_q_pop: assert property (p_q_pop) else $error("queue pop lost");

    property p_sleep_wipe;
        @(posedge core_clk) disable iff (sys_rst)
            state_reg == S_SLEEP |=> cfg_reg == CFG_RST && ram[0] == 12'h0;
    endproperty
    a_sleep_wipe: assert property (p_sleep_wipe) else $error("sleep kept state");

    property p_wake;
        @(posedge core_clk) disable iff (sys_rst) s_sleep_cs |=> state_reg == S_IDLE;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on select");

    property p_to_sleep;
        @(posedge core_clk) disable iff (sys_rst)
            (state_reg == S_IDLE && !cfg_reg.run && cfg_reg.deep_power_select
             && !cfg_reg.soft_rst) |=> state_reg == S_SLEEP;
    endproperty
    a_to_sleep: assert property (p_to_sleep) else $error("sleep not entered");

    property p_zero;
        @(posedge core_clk) disable iff (sys_rst)
            (state_reg == S_WAKE && zcnt > 20'h1) |=> state_reg != S_RUN;
    endproperty
    a_zero: assert property (p_zero) else $error("output before zeroing");

    property p_err;
        @(posedge core_clk) disable iff (sys_rst)
            (fault && running && !cfg_reg.soft_rst) |=> state_fld == SF_ERR;
    endproperty
    a_err: assert property (p_err) else $error("fault not reported");

    property p_direct;
        @(posedge core_clk) disable iff (sys_rst)
            (samp_tick && src_reg == SRC_DIRECT && !wipe) |=> cur == $past(hold_reg);
    endproperty
    a_direct: assert property (p_direct) else $error("direct sample not played");
endmodule

// [bench/hwfe_peer.sv]
// Second linked device on the shared open-drain lockstep wire
`timescale 1ns/1ps
module hwfe_peer (
    input  wire logic core_clk,
    input  wire logic hold_low,
    input  wire logic sync_oe,
    output logic      sync_wire
);
    logic peer_oe_reg;
    // Pulls low until it is ready to start, like a device still zeroing
    always_ff @(posedge core_clk)
    begin
        peer_oe_reg <= hold_low;
    end
    // Pull-up: wire is high only when nobody pulls
    assign sync_wire = ~(sync_oe | peer_oe_reg);
endmodule

// [bench/testbench.sv]
// Self-checking bench of the haptic waveform front end
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    import hwfe_pkg::*;
    logic core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cs_n, fault, sync_wire, sync_out, sync_oe;
    logic event_output_pin, hold_low;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, rs;
    logic [8:0]  sense_level;
    logic [11:0] wave_out;
    int          error_cnt, checks;

    hwfe_top #(.DEPTH(4), .ZERO_CYC(20)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cs_n(cs_n),
        .sense_level(sense_level), .fault(fault), .sync_in(sync_wire),
        .sync_out(sync_out), .sync_oe(sync_oe), .event_output_pin(event_output_pin),
        .wave_out(wave_out));
    hwfe_peer peer (.core_clk(core_clk), .hold_low(hold_low), .sync_oe(sync_oe),
        .sync_wire(sync_wire));

    initial
    begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        if (n == 200) begin error_cnt++; end_sim(); end
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata; rs = rresp;
        if (n == 200) begin error_cnt++; end_sim(); end
    endtask

    task automatic wait_wave(input logic [11:0] v);
        int n;
        for (n = 0; n < 3000 && wave_out !== v; n++) @(posedge core_clk);
        `CHK(wave_out, v)
        if (n == 3000) end_sim();
    endtask

    // Stop, poll for idle, then soft reset; checks defaults afterwards
    task automatic quiesce();
        int n;
        wr(A_CONFIG, 32'h0);
        for (n = 0; n < 50; n++)
        begin
            rd(A_STATUS);
            if (d[1:0] === SF_IDLE) break;
        end
        `CHK(d[1:0], SF_IDLE)
        wr(A_CONFIG, 32'h100);
        rd(A_CONFIG);
        `CHK(d, 32'h0)
        rd(A_SOURCE);
        `CHK(d, 32'h0)
    endtask

    task automatic t_reset_map();
        rd(A_PLAYEND);
        `CHK(d, 32'h3ff)
        rd(A_STATUS);
        `CHK(d[1:0], SF_IDLE)
        rd(8'h20);
        `CHK(rs, RESP_SLVERR)
        `CHK(d, 32'h0)
        wr(8'h22, 32'h1);
        `CHK(rs, RESP_SLVERR)
        $display("test reset_map done");
    endtask

    task automatic t_direct();
        wr(A_SAMPLE, 32'hfffffabc);
        wr(A_CONFIG, 32'h1);
        rd(A_STATUS);
        `CHK(d[1:0], SF_RUN)
        wait_wave(12'habc);
        wr(A_SAMPLE, 32'h00000123);
        wait_wave(12'h123);
        repeat (300) @(posedge core_clk);
        `CHK(wave_out, 12'h123)
        fault <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(A_STATUS);
        `CHK(d[1:0], SF_ERR)
        fault <= 1'b0;
        quiesce();
        $display("test direct done");
    endtask

    task automatic t_queue();
        wr(A_SOURCE, {30'h0, SRC_QUEUE});
        for (int i = 1; i <= 5; i++) wr(A_SAMPLE, 32'h100 + i);
        rd(A_STATUS);
        `CHK(d[12:2], 11'h4)
        wr(A_CONFIG, 32'h1);
        wait_wave(12'h104);
        repeat (400) @(posedge core_clk);
        `CHK(wave_out, 12'h104)
        rd(A_STATUS);
        `CHK(d[12:2], 11'h0)
        quiesce();
        $display("test queue done");
    endtask

    task automatic t_lockstep();
        hold_low <= 1'b1;
        wr(A_SOURCE, {30'h0, SRC_RAM});
        wr(A_RAM, 32'h00000456);
        wr(A_PLAYEND, 32'h0);
        wr(A_CONFIG, 32'h5);
        @(posedge core_clk);
        `CHK(sync_oe, 1'b1)
        repeat (300) @(posedge core_clk);
        `CHK(wave_out, 12'h000)
        `CHK(sync_oe, 1'b0)
        `CHK(sync_out, 1'b0)
        hold_low <= 1'b0;
        wait_wave(12'h456);
        quiesce();
        // Amplitude 0x400 and step 0x200: first synthesized sample sits at mid-scale
        wr(A_RAM, 32'h00000400);
        wr(A_RAM, 32'h00010200);
        wr(A_SOURCE, {30'h0, SRC_TONE});
        wr(A_CONFIG, 32'h1);
        wait_wave(12'h800);
        quiesce();
        $display("test lockstep done");
    endtask

    task automatic t_sense();
        int n;
        wr(A_SENSE, 32'h500);
        wr(A_CONFIG, 32'h400);
        wr(A_SOURCE, 32'h48);
        sense_level <= 9'h150;
        repeat (10) @(posedge core_clk);
        `CHK(event_output_pin, 1'b1)
        rd(A_READBACK);
        `CHK(d, 32'h150)
        rd(A_STATUS);
        `CHK(d[ST_SENSE_BIT], 1'b1)
        sense_level <= 9'h0;
        wr(A_STATUS, 32'h10000);
        @(posedge core_clk);
        `CHK(event_output_pin, 1'b0)
        // Auto-trigger from memory, event pin set to trigger-done
        wr(A_RAM, 32'h00000789);
        wr(A_PLAYEND, 32'h0);
        wr(A_SOURCE, 32'h4a);
        wr(A_CONFIG, 32'ha00);
        sense_level <= 9'h150;
        for (n = 0; n < 1000 && event_output_pin !== 1'b1; n++) @(posedge core_clk);
        `CHK(event_output_pin, 1'b1)
        if (n == 1000) end_sim();
        sense_level <= 9'h0;
        rd(A_STATUS);
        `CHK(d[ST_DONE_BIT], 1'b1)
        `CHK(d[1:0], SF_IDLE)
        quiesce();
        $display("test sense done");
    endtask

    task automatic t_sleep();
        wr(A_PLAYEND, 32'h5);
        wr(A_CONFIG, 32'h2);
        rd(A_STATUS);
        `CHK(d[1:0], SF_SLEEP)
        rd(A_PLAYEND);
        `CHK(d, 32'h3ff)
        cs_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        cs_n <= 1'b1;
        rd(A_STATUS);
        `CHK(d[1:0], SF_IDLE)
        $display("test sleep done");
    endtask

    initial
    begin
        sys_rst = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; cs_n = 1; fault = 0; sense_level = 0;
        hold_low = 0; error_cnt = 0; checks = 0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_reset_map();
        t_direct();
        t_queue();
        t_lockstep();
        t_sense();
        t_sleep();
        end_sim();
    end
endmodule
